/* File: design/aspd_defs.vh */
// aspd_defs.vh: constants for the serial converter power-down control block
// assumes: included by its bare name by the top-level design file; the FIFO file does not include it
`ifndef ASPD_DEFS_VH
`define ASPD_DEFS_VH
// ---------------------------------------------------------------------------
// conversion shape
// ---------------------------------------------------------------------------
`define ASPD_RESULT_BITS 16
`define ASPD_SAMPLE_EDGES 5
`define ASPD_CNT_W 6
// falling edge counts at which each phase begins
`define ASPD_CNT_NULL_BIT 6'h05
`define ASPD_CNT_FIRST_MSB 6'h06
`define ASPD_CNT_FIRST_LSB 6'h15
`define ASPD_CNT_LAST_REPEAT 6'h24
`define ASPD_CNT_DONE 6'h25
// ---------------------------------------------------------------------------
// buffering
// ---------------------------------------------------------------------------
`define ASPD_FIFO_DEPTH 16
`define ASPD_FIFO_AW 4
`endif

/* File: design/aspd_fifo.v */
// aspd_fifo.v: small synchronous FIFO with valid/ready on both sides
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/100ps
module aspd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr];
    assign do_wr = i_in_valid && o_in_ready;
    assign do_rd = o_out_valid && i_out_ready;

    always @(posedge i_sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (do_wr && !do_rd) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (do_rd && !do_wr) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

/* File: design/aspd_top.v */
// aspd_top.v: serial-output converter sequencing and power-down control
// assumes: select and shift clock come from a host in another clock domain;
// result words arrive from the converter core through a 16-word FIFO
//
// How it works
// RULE_01: power down at conversion end or select high
// RULE_02: select low after end: analog only off
// RULE_03: serial logic fully off only while select high
// RULE_04: drive each bit as soon as decided
// RULE_05: select high aborts conversion, powers down
// RULE_06: one bit decision per shift clock cycle
// RULE_07: host preferably clocks at 6.0MHz; the host model clocks at 6.25MHz
// RULE_08: host runs one dummy conversion after power-up
// RULE_09: select falling starts conversion; five sample clocks
// RULE_10: after fifth fall: low bit, then MSB first
// RULE_11: repeat LSB first, then high-impedance until reselect
// RULE_12: launch bits on falling shift clock edges
// RULE_13: select rise mid-conversion tristates and clears sequencing
`timescale 1ns/100ps
`include "aspd_defs.vh"
module aspd_top #(
    parameter RESULT_BITS = `ASPD_RESULT_BITS,
    parameter FIFO_DEPTH = `ASPD_FIFO_DEPTH,
    parameter FIFO_AW = `ASPD_FIFO_AW
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_select_n,
    input wire i_serial_shift_clock,
    input wire i_result_valid,
    output reg o_result_ready,
    input wire [RESULT_BITS-1:0] i_result_data,
    output reg o_serial_data,
    output reg o_serial_data_oe,
    output reg o_analog_powered,
    output reg o_serial_powered,
    output reg o_busy,
    output reg o_dropped
);
    // -----------------------------------------------------------------------
    // synchronisers and edge detection
    // -----------------------------------------------------------------------
    reg sel_meta;
    reg sel_sync;
    reg sel_prev;
    reg sck_meta;
    reg sck_sync;
    reg sck_prev;
    wire sel_fall;
    wire sck_fall;

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sel_meta <= 1'b1;
            sel_sync <= 1'b1;
            sel_prev <= 1'b1;
            sck_meta <= 1'b0;
            sck_sync <= 1'b0;
            sck_prev <= 1'b0;
        end else begin
            sel_meta <= i_select_n;
            sel_sync <= sel_meta;
            sel_prev <= sel_sync;
            sck_meta <= i_serial_shift_clock;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
        end
    end

    assign sel_fall = sel_prev && !sel_sync;
    assign sck_fall = sck_prev && !sck_sync && !sel_sync;

    // -----------------------------------------------------------------------
    // result buffer
    // -----------------------------------------------------------------------
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [RESULT_BITS-1:0] fifo_out_data;
    reg fifo_pop;

    aspd_fifo #(
        .WIDTH(RESULT_BITS),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_in_valid(i_result_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_result_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );

    // occupancy mirror: the registered ready then matches the buffer's own
    // ready in the cycle it is seen, so no word offered while ready is high is lost
    reg [FIFO_AW:0] fill;
    reg [FIFO_AW:0] next_fill;
    wire push_ok;

    assign push_ok = i_result_valid && fifo_in_ready;

    always @* begin
        next_fill = fill;
        if (push_ok && !fifo_pop) begin
            next_fill = fill + {{FIFO_AW{1'b0}}, 1'b1};
        end else if (fifo_pop && !push_ok) begin
            next_fill = fill - {{FIFO_AW{1'b0}}, 1'b1};
        end
    end

    // -----------------------------------------------------------------------
    // bit sequencing
    // -----------------------------------------------------------------------
    localparam ST_OFF = 2'b00;
    localparam ST_SAMPLE = 2'b01;
    localparam ST_SHIFT = 2'b10;
    localparam ST_DONE = 2'b11;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [`ASPD_CNT_W-1:0] edge_cnt;
    reg [`ASPD_CNT_W-1:0] next_edge_cnt;
    reg [RESULT_BITS-1:0] word;
    reg [RESULT_BITS-1:0] next_word;
    reg next_data;
    reg next_oe;
    reg next_pop;
    wire [`ASPD_CNT_W-1:0] msb_idx;
    wire [`ASPD_CNT_W-1:0] lsb_idx;

    // msb-first walk counts down from the top bit, then lsb-first walk up
    assign msb_idx = `ASPD_CNT_FIRST_LSB - edge_cnt;
    assign lsb_idx = edge_cnt - `ASPD_CNT_FIRST_LSB;

    always @* begin
        next_state = state;
        next_edge_cnt = edge_cnt;
        next_word = word;
        next_data = o_serial_data;
        next_oe = o_serial_data_oe;
        next_pop = 1'b0;
        if (sel_sync) begin
            next_state = ST_OFF; // RULE_05
            next_edge_cnt = {`ASPD_CNT_W{1'b0}}; // RULE_13
            next_oe = 1'b0; // RULE_13
            next_data = 1'b0;
        end else begin
            case (state)
                ST_OFF: begin
                    if (sel_fall) begin
                        next_state = ST_SAMPLE; // RULE_09
                        next_edge_cnt = {`ASPD_CNT_W{1'b0}};
                        next_word = fifo_out_valid ? fifo_out_data : {RESULT_BITS{1'b0}};
                        next_pop = fifo_out_valid;
                    end
                end
                ST_SAMPLE: begin
                    if (sck_fall) begin
                        next_edge_cnt = edge_cnt + 6'h01;
                        if (edge_cnt + 6'h01 == `ASPD_CNT_NULL_BIT) begin
                            next_state = ST_SHIFT; // RULE_10
                            next_oe = 1'b1; // RULE_10
                            next_data = 1'b0; // RULE_10
                        end
                    end
                end
                ST_SHIFT: begin
                    if (sck_fall) begin // RULE_12
                        next_edge_cnt = edge_cnt + 6'h01; // RULE_06
                        if (edge_cnt + 6'h01 < `ASPD_CNT_FIRST_LSB + 6'h01) begin
                            next_data = word[msb_idx[3:0] - 4'h1]; // RULE_04
                        end else if (edge_cnt + 6'h01 <= `ASPD_CNT_LAST_REPEAT) begin
                            next_data = word[lsb_idx[3:0] + 4'h1]; // RULE_11
                        end else begin
                            next_state = ST_DONE; // RULE_11
                            next_oe = 1'b0; // RULE_11
                            next_data = 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    next_oe = 1'b0; // RULE_11
                end
                default: begin
                    next_state = ST_OFF;
                end
            endcase
        end
    end

    always @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_OFF;
            edge_cnt <= {`ASPD_CNT_W{1'b0}};
            word <= {RESULT_BITS{1'b0}};
            fifo_pop <= 1'b0;
            fill <= {(FIFO_AW+1){1'b0}};
            o_serial_data <= 1'b0;
            o_serial_data_oe <= 1'b0;
            o_analog_powered <= 1'b0;
            o_serial_powered <= 1'b0;
            o_busy <= 1'b0;
            o_result_ready <= 1'b0;
            o_dropped <= 1'b0;
        end else begin
            state <= next_state;
            edge_cnt <= next_edge_cnt;
            word <= next_word;
            fifo_pop <= next_pop;
            fill <= next_fill;
            o_serial_data <= next_data;
            o_serial_data_oe <= next_oe;
            // analog section runs only while a conversion is in flight
            o_analog_powered <= (next_state == ST_SAMPLE) || (next_state == ST_SHIFT); // RULE_01
            // serial logic stays up after completion while select is low
            o_serial_powered <= !sel_sync; // RULE_02 RULE_03
            o_busy <= (next_state != ST_OFF) && (next_state != ST_DONE);
            o_result_ready <= (next_fill != FIFO_DEPTH[FIFO_AW:0]);
            o_dropped <= i_result_valid && !fifo_in_ready;
        end
    end
endmodule

/* File: test/aspd_props.sv */
// aspd_props.sv: port checker for the power-down control block
// assumes: bound to aspd_top, one clock domain
`timescale 1ns/100ps
module aspd_props #(
    parameter RESULT_BITS = 16
) (
    input wire i_sys_clk,
    input wire i_resetn,
    input wire i_select_n,
    input wire i_serial_shift_clock,
    input wire o_serial_data,
    input wire o_serial_data_oe,
    input wire o_analog_powered,
    input wire o_serial_powered,
    input wire o_busy
);
// ---------------------------------------------------------------------------
// properties
// ---------------------------------------------------------------------------
default clocking cb @(posedge i_sys_clk); endclocking
default disable iff (!i_resetn);
a_idle_serial_off: assert property (i_select_n [*4] |-> !o_serial_powered)
    else $error("serial logic on while deselected");
a_low_serial_on: assert property (!i_select_n [*4] |-> o_serial_powered)
    else $error("serial logic off while selected");
a_abort_stops_all: assert property (i_select_n [*4] |-> !o_analog_powered && !o_busy)
    else $error("conversion still running after deselect");
a_abort_tristate: assert property (i_select_n [*4] |-> !o_serial_data_oe)
    else $error("serial line driven after deselect");
a_null_bit_first: assert property ($rose(o_serial_data_oe) |-> !o_serial_data && !i_select_n)
    else $error("first driven bit not low");
a_bit_on_fall: assert property ($past(o_serial_data_oe) && o_serial_data_oe && $changed(o_serial_data)
    |-> !i_serial_shift_clock)
    else $error("serial bit changed outside low shift clock");
a_done_analog_off: assert property ($fell(o_serial_data_oe) && !i_select_n
    |-> !o_analog_powered && o_serial_powered && !i_serial_shift_clock)
    else $error("power state wrong at end of frame");
a_start_selected: assert property ($rose(o_busy) |-> !i_select_n && o_serial_powered)
    else $error("conversion began without select");
endmodule
bind aspd_top aspd_props #(.RESULT_BITS(RESULT_BITS)) chk_u (.i_sys_clk, .i_resetn, .i_select_n,
    .i_serial_shift_clock, .o_serial_data, .o_serial_data_oe, .o_analog_powered,
    .o_serial_powered, .o_busy);

/* File: test/aspd_host_model.sv */
// aspd_host_model.sv: host that frames conversions on the serial link
// assumes: shift clock period 40 system cycles, still between frames
`timescale 1ns/100ps
module aspd_host_model (
    input wire i_sys_clk,
    input wire i_data,
    input wire i_oe,
    output logic o_select_n,
    output logic o_sclk
);
// ---------------------------------------------------------------------------
// framing
// ---------------------------------------------------------------------------
initial begin
    o_select_n = 1'b1;
    o_sclk = 1'b1;
end
// n shift clocks; bits taken on rising edges while the line is driven
task automatic frame(input int n, output logic [31:0] bits, output int m);
    bits = 32'h0000_0000;
    m = 0;
    @(posedge i_sys_clk) o_select_n <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    repeat (n) begin
        o_sclk <= 1'b0;
        repeat (20) @(posedge i_sys_clk);
        o_sclk <= 1'b1;
        if (i_oe === 1'b1) begin
            bits = {bits[30:0], i_data};
            m++;
        end
        repeat (20) @(posedge i_sys_clk);
    end
    o_select_n <= 1'b1;
    repeat (60) @(posedge i_sys_clk);
endtask
endmodule

/* File: test/aspd_top_tb.sv */
// aspd_top_tb.sv: self-checking bench for aspd_top
// assumes: aspd_host_model and aspd_props compiled before
`timescale 1ns/100ps
module aspd_top_tb;
logic sys_clk, resetn, result_valid, result_ready, serial_data, oe;
logic analog_on, serial_on, busy, dropped, select_n, sclk;
logic [15:0] result_data;
int mismatches = 0;
int compares = 0;
aspd_top dut_u (.i_sys_clk(sys_clk), .i_resetn(resetn), .i_select_n(select_n),
    .i_serial_shift_clock(sclk), .i_result_valid(result_valid), .o_result_ready(result_ready),
    .i_result_data(result_data), .o_serial_data(serial_data), .o_serial_data_oe(oe),
    .o_analog_powered(analog_on), .o_serial_powered(serial_on), .o_busy(busy),
    .o_dropped(dropped));
aspd_host_model host_u (.i_sys_clk(sys_clk), .i_data(serial_data), .i_oe(oe),
    .o_select_n(select_n), .o_sclk(sclk));
// ---------------------------------------------------------------------------
// helpers
// ---------------------------------------------------------------------------
task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
        mismatches++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
function automatic logic [15:0] test_word(input logic [15:0] k);
    return 16'ha5c3 ^ (k * 16'h0f1d);
endfunction
// null bit, msb-first word, then bits 1..15 lsb-first
function automatic logic [31:0] frame_bits(input logic [15:0] w);
    logic [31:0] e;
    e = {1'b0, w, 15'h0000};
    for (int i = 1; i < 16; i++) e[15 - i] = w[i];
    return e;
endfunction
task automatic push(input logic [15:0] w);
    int k;
    @(posedge sys_clk);
    result_valid <= 1'b1;
    result_data <= w;
    k = 0;
    do begin
        @(posedge sys_clk);
        k++;
    end while (result_ready !== 1'b1 && k < 50);
    result_valid <= 1'b0;
    if (k >= 50) begin
        mismatches++;
        final_report();
    end
endtask
// ---------------------------------------------------------------------------
// scenarios
// ---------------------------------------------------------------------------
task automatic scn_dummy;
    logic [31:0] got;
    int m;
    host_u.frame(37, got, m);
    check("empty_frame", frame_bits(16'h0000), got);
    check("empty_count", 32, m);
endtask
task automatic scn_buffer;
    logic [31:0] got;
    logic seen;
    int m;
    for (int k = 0; k < 16; k++) push(test_word(k));
    repeat (3) @(posedge sys_clk);
    check("ready_full", 0, result_ready);
    result_valid <= 1'b1;
    @(posedge sys_clk);
    result_valid <= 1'b0;
    seen = dropped;
    repeat (3) begin
        @(posedge sys_clk);
        seen = seen | dropped;
    end
    check("dropped", 1, seen);
    for (int k = 0; k < 16; k++) begin
        host_u.frame(37, got, m);
        check("word", frame_bits(test_word(k)), got);
        check("count", 32, m);
    end
endtask
task automatic scn_abort;
    logic [31:0] got;
    int m;
    int n;
    for (int j = 0; j < 2; j++) begin
        n = j ? 20 : 8;
        push(test_word(n));
        host_u.frame(n, got, m);
        check("short_bits", frame_bits(test_word(n)) >> (36 - n), got);
        check("short_count", n - 4, m);
        check("short_oe", 0, oe);
        check("short_power", 0, {analog_on, serial_on});
        check("short_busy", 0, busy);
    end
endtask
initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
end
initial begin
    resetn = 1'b0;
    result_valid = 1'b0;
    result_data = 16'h0000;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    scn_dummy();
    scn_buffer();
    scn_abort();
    final_report();
end
endmodule
